//--- src/gsbr_pkg.sv
// package of the gpio serial block receiver: register map, field positions, codes, states
// assumes a 32-bit classic wishbone slave and a 10 MHz clock
package gsbr_pkg;
  localparam logic [8:0] REG_PARAM = 9'h000;
  localparam logic [8:0] REG_ARGS = 9'h004;
  localparam logic [8:0] REG_CMD = 9'h008;
  localparam logic [8:0] REG_STATUS = 9'h00C;
  localparam logic [8:0] REG_RESULT = 9'h010;
  localparam int BUF_SEL_BIT = 8;
  localparam int PRM_BITCLK_LSB = 0;
  localparam int PRM_PIN_LSB = 16;
  localparam int PRM_INV_BIT = 20;
  localparam int PRM_STOP_BIT = 21;
  localparam logic [31:0] PARAM_RST = 32'h0000_0412;
  localparam int ARG_WAIT_LSB = 0;
  localparam int ARG_CTL_LSB = 8;
  localparam int ARG_ADDR_LSB = 16;
  localparam int ARG_SIZE_LSB = 24;
  localparam logic [31:0] ARGS_RST = 32'h0000_0000;
  localparam int CTL_HS_EN = 4;
  localparam int CTL_LONG = 5;
  localparam int CTL_ADDR = 6;
  localparam int CTL_BRK = 7;
  localparam int STA_BUSY_BIT = 0;
  localparam int STA_STOP_BIT = 1;
  localparam int STA_RXB_LSB = 8;
  localparam int STA_CNT_LSB = 16;
  localparam logic [2:0] CMD_RX_BYTE = 3'h1;
  localparam logic [2:0] CMD_RX_BLOCK = 3'h2;
  localparam logic [2:0] CMD_SCAN = 3'h3;
  localparam logic [2:0] CMD_STRING = 3'h4;
  localparam logic [2:0] CMD_DELAY = 3'h5;
  localparam logic [7:0] ERR_OK = 8'h00;
  localparam logic [7:0] ERR_FRAME = 8'h01;
  localparam logic [7:0] ERR_TIMEOUT = 8'h02;
  localparam logic [7:0] ERR_NOMARK = 8'h04;
  localparam logic [7:0] BLK_ERR_BASE = 8'h80;
  localparam logic [15:0] ATT_LONG = 16'h0020;
  localparam logic [15:0] ATT_SHORT = 16'h0008;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] BREAK_BITS = 4'hA;
  localparam int TICK_US = 4096;
  localparam int CLK_KHZ = 10000;
  localparam int TICK_CYC = TICK_US * CLK_KHZ / 1000;
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_HUNT = 7'b0000010,
    S_BIT = 7'b0000100,
    S_FETCH = 7'b0001000,
    S_LOAD = 7'b0010000,
    S_TX = 7'b0100000,
    S_DLY = 7'b1000000
  } gsbr_state_e;
endpackage

//--- src/gsbr_sync.sv
// three-stage input synchroniser for the general purpose pins
// assumes pins change asynchronously to clk
`timescale 1ns/1ps
`default_nettype none
module gsbr_sync #(
  parameter int N = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [N-1:0] d,
  output logic [N-1:0] q
);
  logic [N-1:0] s1, s2, s3;
  logic [N-1:0] next_q;

  // a level counts once the second and third stage agree
  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      q <= '1;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

//--- src/gsbr_mem.sv
// byte buffer: one write port, two registered read ports
// assumes the owner arbitrates the single write port
`timescale 1ns/1ps
`default_nettype none
module gsbr_mem #(
  parameter int W = 8,
  parameter int D = 64,
  parameter int A = 6
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [A-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [A-1:0] raddr_a,
  output logic [W-1:0] rdata_a,
  input wire logic [A-1:0] raddr_b,
  output logic [W-1:0] rdata_b
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule
`default_nettype wire

//--- src/gsbr_top.sv
// serial receiver/transmitter on general purpose pins with wishbone registers
// assumes a classic wishbone master on clk and asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module gsbr_top import gsbr_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe
);
  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[8*i +: 8] = n[8*i +: 8];
      end
    end
    return o;
  endfunction

  function automatic logic [7:0] eff_size(input logic [7:0] s);
    return (s > 8'(DEPTH)) ? 8'(DEPTH) : s;
  endfunction

  // block error code, or field scan code
  function automatic logic [15:0] fail_code(input logic [2:0] m, input logic [7:0] c,
                                            input logic [7:0] s);
    if (m == CMD_SCAN) begin
      return {c, 8'(s - c)};
    end
    return {8'h00, 8'(BLK_ERR_BASE - 8'(s - c))};
  endfunction

  logic [15:0] line;
  logic [31:0] param, next_param;
  logic [31:0] args, next_args;
  logic pend, next_pend;
  logic [31:0] next_dat;
  logic next_ack;
  logic go;
  logic [2:0] go_cmd;
  logic [7:0] rdata_a, rdata_b;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic eng_we;
  logic wb_buf_we;
  logic wr_now;

  gsbr_state_e state, next_state;
  logic [2:0] mode, next_mode;
  logic [16:0] tmr, next_tmr;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic [7:0] txsh, next_txsh;
  logic [TW-1:0] prediv, next_prediv;
  logic [7:0] wcnt, next_wcnt;
  logic [7:0] cnt, next_cnt;
  logic [15:0] att, next_att;
  logic need_brk, next_need_brk;
  logic need_addr, next_need_addr;
  logic [15:0] result, next_result;
  logic [7:0] rxb, next_rxb;
  logic [AW-1:0] eaddr, next_eaddr;
  logic prev_mark, next_prev_mark;
  logic hs_on, next_hs_on;
  logic [3:0] hs_pin, next_hs_pin;
  logic [15:0] next_pin_out, next_pin_oe;

  logic [15:0] bitclk;
  logic [3:0] lpin;
  logic inv, stop_chk, mark, fe, busy;
  logic [7:0] waitv, ctl, addrv, size;
  logic [15:0] limit;

  gsbr_sync #(.N(16)) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .d(pin_in),
    .q(line)
  );

  gsbr_mem #(.W(8), .D(DEPTH), .A(AW)) u_mem (
    .clk(clk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr_a(wb_adr_i[AW+1:2]),
    .rdata_a(rdata_a),
    .raddr_b(eaddr),
    .rdata_b(rdata_b)
  );

  assign bitclk = param[PRM_BITCLK_LSB +: 16];
  assign lpin = param[PRM_PIN_LSB +: 4];
  assign inv = param[PRM_INV_BIT];
  assign stop_chk = param[PRM_STOP_BIT];
  assign waitv = args[ARG_WAIT_LSB +: 8];
  assign ctl = args[ARG_CTL_LSB +: 8];
  assign addrv = args[ARG_ADDR_LSB +: 8];
  assign size = eff_size(args[ARG_SIZE_LSB +: 8]);
  assign mark = line[lpin] ^ inv;
  assign fe = stop_chk & ~mark;
  assign busy = (state != S_IDLE);
  assign limit = 16'(size) * (ctl[CTL_LONG] ? ATT_LONG : ATT_SHORT);
  assign wr_now = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & ~busy;
  assign wb_buf_we = wr_now & wb_adr_i[BUF_SEL_BIT] & wb_sel_i[0];
  assign mem_we = eng_we | wb_buf_we;
  assign mem_wa = eng_we ? cnt[AW-1:0] : wb_adr_i[AW+1:2];
  assign mem_wd = eng_we ? sh : wb_dat_i[7:0];

  // wishbone slave: request seen, one cycle pending, then ack with data
  always_comb begin
    next_param = param;
    next_args = args;
    next_pend = wb_cyc_i & wb_stb_i & ~pend & ~wb_ack_o;
    next_ack = pend;
    next_dat = 32'h0000_0000;
    go = 1'b0;
    go_cmd = wb_dat_i[2:0];
    if (pend) begin
      if (wb_adr_i[BUF_SEL_BIT]) begin
        next_dat = {24'h00_0000, rdata_a};
      end else begin
        unique case (wb_adr_i)
          REG_PARAM: next_dat = param;
          REG_ARGS: next_dat = args;
          REG_STATUS: begin
            next_dat[STA_BUSY_BIT] = busy;
            next_dat[STA_STOP_BIT] = stop_chk;
            next_dat[STA_RXB_LSB +: 8] = rxb;
            next_dat[STA_CNT_LSB +: 8] = cnt;
          end
          REG_RESULT: next_dat = {16'h0000, result};
          default: next_dat = 32'h0000_0000;
        endcase
      end
    end
    // writes land on the edge at which the master sees ack
    if (wr_now && !wb_adr_i[BUF_SEL_BIT]) begin
      unique case (wb_adr_i)
        REG_PARAM: next_param = merge(param, wb_dat_i, wb_sel_i);
        REG_ARGS: next_args = merge(args, wb_dat_i, wb_sel_i);
        REG_CMD: go = wb_sel_i[0];
        default: go = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      param <= PARAM_RST;
      args <= ARGS_RST;
      pend <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      param <= next_param;
      args <= next_args;
      pend <= next_pend;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // serial engine
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_tmr = tmr;
    next_bitn = bitn;
    next_sh = sh;
    next_txsh = txsh;
    next_prediv = prediv;
    next_wcnt = wcnt;
    next_cnt = cnt;
    next_att = att;
    next_need_brk = need_brk;
    next_need_addr = need_addr;
    next_result = result;
    next_rxb = rxb;
    next_eaddr = eaddr;
    next_prev_mark = prev_mark;
    next_hs_on = hs_on;
    next_hs_pin = hs_pin;
    next_pin_out = pin_out;
    next_pin_oe = pin_oe;
    eng_we = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (go) begin
          next_mode = go_cmd;
          next_result = 16'h0000;
          next_cnt = 8'h00;
          next_att = 16'h0000;
          next_need_brk = ctl[CTL_BRK] & (go_cmd == CMD_RX_BLOCK);
          next_need_addr = ctl[CTL_ADDR] & (go_cmd == CMD_RX_BLOCK);
          next_wcnt = waitv;
          next_prediv = '0;
          next_prev_mark = mark;
          if (go_cmd == CMD_RX_BYTE) begin
            if (!mark) begin
              next_result = {8'h00, ERR_NOMARK};
            end else begin
              next_state = S_HUNT;
            end
          end else if (go_cmd == CMD_RX_BLOCK || go_cmd == CMD_SCAN) begin
            if (size != 8'h00) begin
              next_state = S_HUNT;
            end
          end else if (go_cmd == CMD_STRING) begin
            next_eaddr = '0;
            next_state = S_FETCH;
          end else if (go_cmd == CMD_DELAY) begin
            next_tmr = {1'b0, bitclk} + {2'b00, bitclk[15:1]} - 17'h00001;
            next_state = S_DLY;
          end
          // handshake only for a reception that really starts, so it is always released
          if (ctl[CTL_HS_EN] && next_state == S_HUNT) begin
            next_hs_on = 1'b1;
            next_hs_pin = ctl[3:0];
            next_pin_out[ctl[3:0]] = 1'b1;
            next_pin_oe[ctl[3:0]] = 1'b1;
          end
        end
      end
      S_HUNT: begin
        next_prev_mark = mark;
        if (prev_mark && !mark) begin
          next_tmr = {2'b00, bitclk[15:1]};
          next_bitn = 4'h0;
          next_state = S_BIT;
        end else if (waitv != 8'h00) begin
          next_prediv = prediv + TW'(1);
          if (prediv == TW'(TICK_CYCLES - 1)) begin
            next_prediv = '0;
            next_wcnt = wcnt - 8'h01;
            if (wcnt == 8'h01) begin
              next_state = S_IDLE;
              next_result = (mode == CMD_RX_BYTE) ? {8'h00, ERR_TIMEOUT} :
                            fail_code(mode, cnt, size);
            end
          end
        end
      end
      S_BIT: begin
        if (tmr != 17'h00000) begin
          next_tmr = tmr - 17'h00001;
        end else begin
          next_tmr = {1'b0, bitclk} - 17'h00001;
          next_bitn = bitn + 4'h1;
          if (bitn == 4'h0) begin
            if (mark) begin
              next_state = S_HUNT;
            end
          end else if (bitn <= DATA_BITS) begin
            next_sh = {mark, sh[7:1]};
          end else begin
            next_prev_mark = mark;
            next_wcnt = waitv;
            next_prediv = '0;
            next_state = S_HUNT;
            if (mode == CMD_RX_BYTE) begin
              next_rxb = sh;
              next_result = {8'h00, fe ? ERR_FRAME : ERR_OK};
              next_state = S_IDLE;
            end else begin
              next_att = att + 16'h0001;
              next_rxb = sh;
              if (need_brk) begin
                if (fe && sh == 8'h00) begin
                  next_need_brk = 1'b0;
                end
              end else if (need_addr) begin
                if (!fe && sh == addrv) begin
                  next_need_addr = 1'b0;
                end
              end else if (fe) begin
                next_state = S_IDLE;
                next_result = fail_code(mode, cnt, size);
              end else begin
                eng_we = 1'b1;
                next_cnt = cnt + 8'h01;
                if (cnt + 8'h01 == size) begin
                  next_state = S_IDLE;
                  next_result = (mode == CMD_SCAN) ? {size, 8'h00} : 16'h0000;
                end
              end
              if (next_state == S_HUNT && att + 16'h0001 >= limit) begin
                next_state = S_IDLE;
                next_result = fail_code(mode, next_cnt, size);
              end
            end
          end
        end
      end
      S_FETCH: next_state = S_LOAD;
      S_LOAD: begin
        if (rdata_b == 8'h00) begin
          next_state = S_IDLE;
        end else begin
          next_txsh = rdata_b;
          next_bitn = 4'h0;
          next_tmr = {1'b0, bitclk} - 17'h00001;
          next_pin_out[lpin] = inv;
          next_pin_oe[lpin] = 1'b1;
          next_state = S_TX;
        end
      end
      S_TX: begin
        if (tmr != 17'h00000) begin
          next_tmr = tmr - 17'h00001;
        end else begin
          next_tmr = {1'b0, bitclk} - 17'h00001;
          next_bitn = bitn + 4'h1;
          if (bitn < DATA_BITS) begin
            next_pin_out[lpin] = txsh[0] ^ inv;
            next_txsh = {1'b0, txsh[7:1]};
          end else if (bitn == DATA_BITS) begin
            next_pin_out[lpin] = ~inv;
          end else begin
            next_eaddr = eaddr + AW'(1);
            next_state = (eaddr == AW'(DEPTH - 1)) ? S_IDLE : S_FETCH;
          end
        end
      end
      S_DLY: begin
        if (tmr == 17'h00000) begin
          next_state = S_IDLE;
        end else begin
          next_tmr = tmr - 17'h00001;
        end
      end
    endcase
    if (state != S_IDLE && next_state == S_IDLE && hs_on) begin
      next_hs_on = 1'b0;
      next_pin_out[hs_pin] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      mode <= 3'h0;
      tmr <= 17'h00000;
      bitn <= 4'h0;
      sh <= 8'h00;
      txsh <= 8'h00;
      prediv <= '0;
      wcnt <= 8'h00;
      cnt <= 8'h00;
      att <= 16'h0000;
      need_brk <= 1'b0;
      need_addr <= 1'b0;
      result <= 16'h0000;
      rxb <= 8'h00;
      eaddr <= '0;
      prev_mark <= 1'b0;
      hs_on <= 1'b0;
      hs_pin <= 4'h0;
      pin_out <= 16'h0000;
      pin_oe <= 16'h0000;
    end else if (ce) begin
      state <= next_state;
      mode <= next_mode;
      tmr <= next_tmr;
      bitn <= next_bitn;
      sh <= next_sh;
      txsh <= next_txsh;
      prediv <= next_prediv;
      wcnt <= next_wcnt;
      cnt <= next_cnt;
      att <= next_att;
      need_brk <= next_need_brk;
      need_addr <= next_need_addr;
      result <= next_result;
      rxb <= next_rxb;
      eaddr <= next_eaddr;
      prev_mark <= next_prev_mark;
      hs_on <= next_hs_on;
      hs_pin <= next_hs_pin;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end
endmodule
`default_nettype wire

//--- tb/gsbr_checker.sv
// port-level assertions for the serial block receiver top
// assumes a single clock domain and writes to PARAM/ARGS only while idle
`timescale 1ns/1ps
`default_nettype none
module gsbr_checker import gsbr_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe
);
  logic [31:0] param, args, next_param, next_args;
  logic [15:0] allow;
  logic [3:0] hs;
  logic wr_hit;
  assign wr_hit = wb_ack_o && wb_we_i && wb_cyc_i && wb_stb_i;
  assign hs = args[ARG_CTL_LSB +: 4];
  assign allow = (args[ARG_CTL_LSB + CTL_HS_EN] ? (16'h1 << hs) : 16'h0)
                 | (16'h1 << param[PRM_PIN_LSB +: 4]);
  always_comb begin
    next_param = param;
    next_args = args;
    if (wr_hit && wb_adr_i == REG_PARAM) next_param = wb_dat_i;
    if (wr_hit && wb_adr_i == REG_ARGS) next_args = wb_dat_i;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      param <= PARAM_RST;
      args <= ARGS_RST;
    end else begin
      param <= next_param;
      args <= next_args;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_answer: assert property (s_req |-> ##[1:3] wb_ack_o)
    else $error("bus request not answered in time");
  a_ack_single: assert property ($rose(wb_ack_o) |-> s_pulse)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 9'h014
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_oe_sticky: assert property ((~pin_oe & $past(pin_oe)) == 16'h0)
    else $error("pin enable dropped");
  a_oe_allowed: assert property ((pin_oe & ~$past(pin_oe) & ~allow) == 16'h0)
    else $error("unexpected pin enabled");
  a_hs_high: assert property ($rose(pin_oe[hs]) && args[12] |-> pin_out[hs])
    else $error("handshake not asserted high");
  a_reset_quiet: assert property ($fell(reset) |-> !wb_ack_o && pin_oe == 16'h0)
    else $error("outputs active after reset");
endmodule
bind gsbr_top gsbr_checker #(.TICK_CYCLES(TICK_CYCLES), .DEPTH(DEPTH)) u_chk (
  .clk(clk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe));
`default_nettype wire

//--- tb/gsbr_line_model.sv
// far-side serial transmitter and a listener for the string sender
// assumes calls start right after a rising edge, non-inverted levels
`timescale 1ns/1ps
`default_nettype none
module gsbr_line_model #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic tx_pin,
  output var logic line
);
  initial line = 1'b1;
  task automatic hold(input logic lvl, input int n);
    line <= lvl;
    repeat (n) @(posedge clk);
  endtask
  task automatic send(input logic [7:0] b, input logic stop_ok);
    hold(1'b0, BIT);
    for (int i = 0; i < 8; i++) hold(b[i], BIT);
    hold(stop_ok, BIT);
    hold(1'b1, BIT);
  endtask
  task automatic recv(output logic [7:0] b, output logic seen);
    int n;
    n = 0;
    while (tx_pin !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    seen = (tx_pin === 1'b0);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = tx_pin;
    end
    repeat (BIT) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the serial block receiver
// assumes a 16-clock bit period, serial pin 0 and a short start tick
`timescale 1ns/1ps
`default_nettype none
module tb_top import gsbr_pkg::*;;
  localparam int BT = 16;
  localparam logic [31:0] P_ON = (32'h1 << PRM_STOP_BIT) | 32'(BT);
  localparam logic [31:0] P_OFF = 32'(BT);
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:0] adr = 9'h000;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] rdat, q;
  logic ack, line;
  logic [15:0] pout, poe;
  int n_mismatch = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  gsbr_top #(.TICK_CYCLES(20), .DEPTH(64)) dut (.clk(clk), .reset(reset), .ce(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_in({15'h7FFF, line}),
    .pin_out(pout), .pin_oe(poe));
  gsbr_line_model #(.BIT(BT)) mdl (.clk(clk), .tx_pin(poe[0] ? pout[0] : 1'b1),
    .line(line));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] args(input logic [7:0] w, c, a, s);
    return {s, a, c, w};
  endfunction
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask
  task automatic finish_cmd(input logic [15:0] exp);
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
    end while (q[STA_BUSY_BIT] !== 1'b0);
    rd_chk(REG_RESULT, {16'h0, exp}, "result");
  endtask
  task automatic t_regs();
    rd_chk(REG_PARAM, PARAM_RST, "param reset");
    rd_chk(REG_ARGS, ARGS_RST, "args reset");
    bus(1'b1, 9'h014, 32'hFFFF_FFFF);
    rd_chk(9'h014, 32'h0, "unmapped");
    bus(1'b1, REG_PARAM, P_ON);
    rd_chk(REG_PARAM, P_ON, "param");
    rd_chk(REG_STATUS, 32'(1 << STA_STOP_BIT), "status stop");
  endtask
  task automatic t_single();
    bus(1'b1, REG_ARGS, args(8'h00, 8'h13, 8'h00, 8'h00));
    bus(1'b1, REG_CMD, 32'(CMD_RX_BYTE));
    mdl.send(8'hA5, 1'b1);
    finish_cmd({8'h0, ERR_OK});
    bus(1'b0, REG_STATUS, 32'h0);
    chk({24'h0, q[STA_RXB_LSB +: 8]}, 32'hA5, "byte");
    chk({30'h0, pout[3], poe[3]}, 32'h1, "handshake end");
    bus(1'b1, REG_CMD, 32'(CMD_RX_BYTE));
    mdl.send(8'h3C, 1'b0);
    finish_cmd({8'h0, ERR_FRAME});
    bus(1'b1, REG_PARAM, P_OFF);
    bus(1'b1, REG_CMD, 32'(CMD_RX_BYTE));
    mdl.send(8'h3C, 1'b0);
    finish_cmd({8'h0, ERR_OK});
    bus(1'b1, REG_PARAM, P_ON);
  endtask
  task automatic t_errors();
    bus(1'b1, REG_ARGS, args(8'h01, 8'h13, 8'h00, 8'h00));
    bus(1'b1, REG_CMD, 32'(CMD_RX_BYTE));
    finish_cmd({8'h0, ERR_TIMEOUT});
    mdl.hold(1'b0, 4);
    bus(1'b1, REG_CMD, 32'(CMD_RX_BYTE));
    finish_cmd({8'h0, ERR_NOMARK});
    chk({31'h0, pout[3]}, 32'h0, "handshake after no mark");
    mdl.hold(1'b1, 4);
  endtask
  task automatic t_blocks();
    logic [7:0] exp [4] = '{8'h01, 8'h02, 8'h03, 8'hEE};
    bus(1'b1, 9'h10C, 32'hEE);
    bus(1'b1, REG_ARGS, args(8'h00, 8'h40, 8'h5A, 8'd3));
    bus(1'b1, REG_CMD, 32'(CMD_RX_BLOCK));
    foreach (exp[i]) mdl.send(i == 0 ? 8'h11 : (i == 1 ? 8'h5A : exp[i - 2]), 1'b1);
    mdl.send(8'h03, 1'b1);
    finish_cmd(16'h0);
    for (int i = 0; i < 4; i++) rd_chk(9'h100 + 9'(4 * i), {24'h0, exp[i]}, "buf");
    bus(1'b1, REG_ARGS, args(8'h00, 8'h80, 8'h00, 8'd2));
    bus(1'b1, REG_CMD, 32'(CMD_RX_BLOCK));
    mdl.hold(1'b0, 13 * BT);
    mdl.hold(1'b1, BT);
    mdl.send(8'h21, 1'b1);
    mdl.send(8'h22, 1'b1);
    finish_cmd(16'h0);
    rd_chk(9'h104, 32'h22, "break block");
    bus(1'b1, REG_ARGS, args(8'h02, 8'h00, 8'h00, 8'd4));
    bus(1'b1, REG_CMD, 32'(CMD_RX_BLOCK));
    mdl.send(8'h61, 1'b1);
    mdl.send(8'h62, 1'b1);
    finish_cmd(16'(128 - 2));
  endtask
  task automatic t_limits();
    bus(1'b1, REG_ARGS, args(8'h00, 8'h40, 8'h5A, 8'd1));
    bus(1'b1, REG_CMD, 32'(CMD_RX_BLOCK));
    repeat (8) mdl.send(8'h33, 1'b1);
    finish_cmd(16'(128 - 1));
    bus(1'b1, REG_ARGS, args(8'h00, 8'h60, 8'h5A, 8'd1));
    bus(1'b1, REG_CMD, 32'(CMD_RX_BLOCK));
    repeat (9) mdl.send(8'h33, 1'b1);
    mdl.send(8'h5A, 1'b1);
    mdl.send(8'h44, 1'b1);
    finish_cmd(16'h0);
    rd_chk(9'h100, 32'h44, "long block");
    bus(1'b1, REG_ARGS, args(8'h00, 8'h00, 8'h00, 8'd2));
    bus(1'b1, REG_CMD, 32'(CMD_SCAN));
    mdl.send(8'h71, 1'b1);
    mdl.send(8'h72, 1'b1);
    finish_cmd(16'h0200);
    chk({16'h0, poe}, 32'h8, "pins untouched");
  endtask
  task automatic t_tx();
    logic [7:0] b;
    logic seen;
    time t0;
    bus(1'b1, 9'h100, 32'h41);
    bus(1'b1, 9'h104, 32'h42);
    bus(1'b1, 9'h108, 32'h00);
    bus(1'b1, 9'h10C, 32'h43);
    bus(1'b1, REG_CMD, 32'(CMD_STRING));
    mdl.recv(b, seen);
    chk({23'h0, seen, b}, 32'h141, "tx first");
    mdl.recv(b, seen);
    chk({23'h0, seen, b}, 32'h142, "tx second");
    mdl.recv(b, seen);
    chk({31'h0, seen}, 32'h0, "tx after null");
    finish_cmd(16'h0);
    bus(1'b1, REG_CMD, 32'(CMD_DELAY));
    t0 = $time;
    bus(1'b1, REG_ARGS, 32'hFFFF_FFFF);
    finish_cmd(16'h0);
    t0 = ($time - t0) / 100;
    chk({31'h0, t0 >= BT + BT / 2 - 10 && t0 <= BT + BT / 2 + 10}, 32'h1, "delay");
    rd_chk(REG_ARGS, args(8'h00, 8'h00, 8'h00, 8'd2), "write while busy");
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_single();
    t_errors();
    t_blocks();
    t_limits();
    t_tx();
    give_verdict();
  end
endmodule
`default_nettype wire
